// [inc/pasc_pkg.sv]
// Package of the auto-negotiation and special control register bank.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package pasc_pkg;

    // =====================================================================
    // Register indices and address width
    localparam logic [5:0] PARTNER_IDX   = 6'h05;
    localparam logic [5:0] EXPANSION_IDX = 6'h06;
    localparam logic [5:0] RSVD_LO_IDX   = 6'h08;
    localparam logic [5:0] RSVD_HI_IDX   = 6'h0f;
    localparam logic [5:0] STATUS_IDX    = 6'h10;
    localparam logic [5:0] SPECIAL_IDX   = 6'h11;
    localparam logic [5:0] RSVD18_IDX    = 6'h12;
    localparam int         ADDR_W        = 8;

    // =====================================================================
    // Field positions
    localparam int PA_NEXT_PAGE   = 15;
    localparam int PA_ACK         = 14;
    localparam int PA_FAULT       = 13;
    localparam int PA_TECH_LSB    = 5;
    localparam int EX_PD_FAULT    = 4;
    localparam int EX_LP_NP       = 3;
    localparam int EX_LOCAL_NP    = 2;
    localparam int EX_PAGE_RX     = 1;
    localparam int EX_LP_AN       = 0;
    localparam int ST_RPD_DIS     = 13;
    localparam int ST_IN_SYNC     = 11;
    localparam int ST_PD100       = 10;
    localparam int ST_PD10        = 9;
    localparam int ST_POLARITY    = 8;
    localparam int ST_ADDR_LSB    = 2;
    localparam int ST_SPEED       = 1;
    localparam int ST_DUPLEX      = 0;

    // =====================================================================
    // Reset values and masks
    localparam logic [15:0] STATUS_RW_MASK  = 16'hf000;
    localparam logic [15:0] STATUS_RW_RESET = 16'h2000;
    localparam logic [15:0] SPECIAL_RESET   = 16'h0000;
    localparam logic [1:0]  POWER_RESET     = 2'h3;
    localparam logic        LOCAL_NP_VALUE  = 1'h0;
    localparam logic [1:0]  STRAP_TAKE_CNT  = 2'h2;

endpackage : pasc_pkg

// [verilog/pasc_regs.sv]
// Register bank: partner ability, expansion, status and special control.
// Assumes an APB master on sys_clk_in; status and event inputs come from
// logic on the same clock; only the address strap is an outside pin.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Partner ability word mirrors partner page fields
// - Bit 14 shows partner advertisement received
// - Parallel fault latches high, clears on read
// - Page received latches high, clears on read
// - Bits 3, 0 show partner abilities
// - Local next-page bit reads zero
// - Registers 8 to 15 hold nothing
// - Register 18 reads all zero
// - Bit 13 disables automatic reduced power-down
// - Bit 11 shows 100M deserializer in sync
// - Bits 10, 9 show unit power-down
// - Bit 8 shows reversed 10M polarity
// - Bits 6:2 show strapped management address
// - Bits 1, 0 show speed and duplex
// - Bits 15, 14 bypass scrambler and coder
// - Bits 13, 12 force test patterns
// - Bits 11, 10 force link, symbol errors
// - Bits 9, 8 disable carrier, power-down
// - Bits 7, 6 loopback, tri-state driver
// - Bits 5, 4 force polarity, disable correction
// - Bits 3, 2 squelch test, extended squelch
// - Bits 1, 0 disable link check, jabber
module pasc_regs (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Partner page from the negotiation logic
    input  wire logic        lp_next_page_in,
    input  wire logic        lp_ack_in,
    input  wire logic        lp_remote_fault_in,
    input  wire logic [7:0]  lp_tech_in,
    input  wire logic [4:0]  lp_selector_in,
    input  wire logic        lp_np_able_in,
    input  wire logic        lp_an_able_in,
    // Negotiation events, one-cycle pulses
    input  wire logic        pd_fault_evt_in,
    input  wire logic        page_rx_evt_in,
    // Unit status
    input  wire logic        rx_in_sync_in,
    input  wire logic        pd100_in,
    input  wire logic        pd10_in,
    input  wire logic        polarity_rev_in,
    input  wire logic        speed_100_in,
    input  wire logic        full_duplex_in,
    // Address strap pins
    input  wire logic [4:0]  addr_strap_in,
    // Controls to the units
    output logic             rpd_disable_out,
    output logic             scrambler_bypass_out,
    output logic             coder_bypass_out,
    output logic             force_h_pattern_out,
    output logic             force_34_pattern_out,
    output logic             force_link_100_out,
    output logic             symbol_err_en_out,
    output logic             carrier_sense_dis_out,
    output logic             dyn_pd_dis_out,
    output logic             an_loopback_out,
    output logic             tx_tristate_out,
    output logic             force_pol_rev_out,
    output logic             auto_pol_dis_out,
    output logic             squelch_test_dis_out,
    output logic             ext_squelch_en_out,
    output logic             link_check_dis_out,
    output logic             jabber_dis_out
);

    // =====================================================================
    // State
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        pd_fault;
        logic        page_rx;
        logic        pd_fault_seen;
        logic        page_rx_seen;
        logic [15:0] status_rw;
        logic [15:0] special;
        logic [1:0]  power;
        logic [4:0]  strap_s1;
        logic [4:0]  strap_s2;
        logic [4:0]  mgmt_addr;
        logic [1:0]  strap_cnt;
    } pasc_state_type;

    pasc_state_type st_q;
    pasc_state_type st_d;

    // =====================================================================
    // Decode
    logic [5:0]  idx;
    logic        setup;
    logic        done;
    logic        hit_partner;
    logic        hit_exp;
    logic        hit_status;
    logic        hit_special;
    logic        hit_zero;
    logic        mapped;
    logic [15:0] rd_word;
    logic [15:0] partner_word;
    logic [15:0] exp_word;
    logic [15:0] status_word;

    assign idx         = paddr_in[7:2];
    assign setup       = psel_in && !penable_in;
    assign done        = psel_in && penable_in && st_q.pready;
    assign hit_partner = (idx == pasc_pkg::PARTNER_IDX);
    assign hit_exp     = (idx == pasc_pkg::EXPANSION_IDX);
    assign hit_status  = (idx == pasc_pkg::STATUS_IDX);
    assign hit_special = (idx == pasc_pkg::SPECIAL_IDX);
    assign hit_zero    = (idx == pasc_pkg::RSVD18_IDX) ||
                         (idx >= pasc_pkg::RSVD_LO_IDX && idx <= pasc_pkg::RSVD_HI_IDX);
    assign mapped      = hit_partner || hit_exp || hit_status || hit_special || hit_zero;

    always_comb begin
        partner_word = {lp_next_page_in, lp_ack_in, lp_remote_fault_in,
                        lp_tech_in, lp_selector_in};
        exp_word = 16'h0000;
        exp_word[pasc_pkg::EX_PD_FAULT] = st_q.pd_fault;
        exp_word[pasc_pkg::EX_LP_NP]    = lp_np_able_in;
        exp_word[pasc_pkg::EX_LOCAL_NP] = pasc_pkg::LOCAL_NP_VALUE;
        exp_word[pasc_pkg::EX_PAGE_RX]  = st_q.page_rx;
        exp_word[pasc_pkg::EX_LP_AN]    = lp_an_able_in;
        status_word = st_q.status_rw & pasc_pkg::STATUS_RW_MASK;
        status_word[pasc_pkg::ST_IN_SYNC]  = rx_in_sync_in;
        status_word[pasc_pkg::ST_PD100]    = st_q.power[1];
        status_word[pasc_pkg::ST_PD10]     = st_q.power[0];
        status_word[pasc_pkg::ST_POLARITY] = polarity_rev_in;
        status_word[pasc_pkg::ST_ADDR_LSB +: 5] = st_q.mgmt_addr;
        status_word[pasc_pkg::ST_SPEED]    = speed_100_in;
        status_word[pasc_pkg::ST_DUPLEX]   = full_duplex_in;
        if (hit_partner) begin
            rd_word = partner_word;
        end else if (hit_exp) begin
            rd_word = exp_word;
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_special) begin
            rd_word = st_q.special;
        end else begin
            rd_word = 16'h0000;
        end
    end

    // =====================================================================
    // Next state
    always_comb begin
        st_d = st_q;
        // Answer one cycle after setup, so access phases have one wait-free edge
        st_d.pready  = setup;
        st_d.pslverr = setup && !mapped;
        if (setup) begin
            st_d.prdata = pwrite_in ? 32'h0000_0000 : {16'h0000, rd_word};
        end
        // Remember which latched bits this read returns
        if (setup && !pwrite_in && hit_exp) begin
            st_d.pd_fault_seen = st_q.pd_fault;
            st_d.page_rx_seen  = st_q.page_rx;
        end
        // Clear returned bits at completion; a new event wins
        if (done && !pwrite_in && hit_exp) begin
            st_d.pd_fault = st_q.pd_fault && !st_q.pd_fault_seen;
            st_d.page_rx  = st_q.page_rx && !st_q.page_rx_seen;
        end
        if (pd_fault_evt_in) begin
            st_d.pd_fault = 1'h1;
        end
        if (page_rx_evt_in) begin
            st_d.page_rx = 1'h1;
        end
        // Writes take effect at the completing edge
        if (done && pwrite_in && hit_status) begin
            st_d.status_rw = pwdata_in[15:0] & pasc_pkg::STATUS_RW_MASK;
        end
        if (done && pwrite_in && hit_special) begin
            st_d.special = pwdata_in[15:0];
        end
        st_d.power = {pd100_in, pd10_in};
        // Strap synchroniser and one capture after reset release
        st_d.strap_s1 = addr_strap_in;
        st_d.strap_s2 = st_q.strap_s1;
        if (st_q.strap_cnt != 2'h3) begin
            st_d.strap_cnt = st_q.strap_cnt + 2'h1;
        end
        if (st_q.strap_cnt == pasc_pkg::STRAP_TAKE_CNT) begin
            st_d.mgmt_addr = st_q.strap_s2;
        end
    end

    // =====================================================================
    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_q           <= '0;
            st_q.status_rw <= pasc_pkg::STATUS_RW_RESET;
            st_q.special   <= pasc_pkg::SPECIAL_RESET;
            st_q.power     <= pasc_pkg::POWER_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // Outputs
    assign prdata_out            = st_q.prdata;
    assign pready_out            = st_q.pready;
    assign pslverr_out           = st_q.pslverr;
    assign rpd_disable_out       = st_q.status_rw[pasc_pkg::ST_RPD_DIS];
    assign scrambler_bypass_out  = st_q.special[15];
    assign coder_bypass_out      = st_q.special[14];
    assign force_h_pattern_out   = st_q.special[13];
    assign force_34_pattern_out  = st_q.special[12];
    assign force_link_100_out    = st_q.special[11];
    assign symbol_err_en_out     = st_q.special[10];
    assign carrier_sense_dis_out = st_q.special[9];
    assign dyn_pd_dis_out        = st_q.special[8];
    assign an_loopback_out       = st_q.special[7];
    assign tx_tristate_out       = st_q.special[6];
    assign force_pol_rev_out     = st_q.special[5];
    assign auto_pol_dis_out      = st_q.special[4];
    assign squelch_test_dis_out  = st_q.special[3];
    assign ext_squelch_en_out    = st_q.special[2];
    assign link_check_dis_out    = st_q.special[1];
    assign jabber_dis_out        = st_q.special[0];

    // =====================================================================
    // Assertions
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    partner_read_a: assert property (
        setup && !pwrite_in && hit_partner |=> prdata_out[15:0] == $past(partner_word))
        else $error("partner word read wrong");
    ack_bit_a: assert property (
        setup && !pwrite_in && hit_partner && lp_ack_in |=> prdata_out[pasc_pkg::PA_ACK])
        else $error("acknowledge bit not returned");
    fault_latch_a: assert property (
        pd_fault_evt_in |=> st_q.pd_fault)
        else $error("parallel fault not latched");
    page_clear_a: assert property (
        done && !pwrite_in && hit_exp && st_q.page_rx_seen && !page_rx_evt_in
        |=> !st_q.page_rx)
        else $error("page bit not cleared by read");
    local_np_a: assert property (
        pready_out && $past(hit_exp) |-> !prdata_out[pasc_pkg::EX_LOCAL_NP])
        else $error("local next page bit set");
    zero_regs_a: assert property (
        setup && hit_zero |=> prdata_out == 32'h0000_0000 && !pslverr_out)
        else $error("reserved register not zero");
    status_read_a: assert property (
        setup && !pwrite_in && hit_status
        |=> prdata_out[pasc_pkg::ST_IN_SYNC] == $past(rx_in_sync_in)
            && prdata_out[1:0] == $past({speed_100_in, full_duplex_in}))
        else $error("status bits read wrong");
    special_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {scrambler_bypass_out, coder_bypass_out} == $past(pwdata_in[15:14]))
        else $error("special control write lost");
    set_wins_a: assert property (
        done && !pwrite_in && hit_exp && pd_fault_evt_in |=> st_q.pd_fault)
        else $error("event lost during clearing read");
    answer_time_a: assert property (
        setup |=> pready_out ##1 !pready_out || (psel_in && !penable_in))
        else $error("answer timing wrong");
    page_latch_a: assert property (
        page_rx_evt_in |=> st_q.page_rx)
        else $error("page received not latched");
    fault_clear_a: assert property (
        done && !pwrite_in && hit_exp && st_q.pd_fault_seen && !pd_fault_evt_in
        |=> !st_q.pd_fault)
        else $error("fault bit not cleared by read");
    exp_read_a: assert property (
        setup && !pwrite_in && hit_exp
        |=> prdata_out[pasc_pkg::EX_LP_NP] == $past(lp_np_able_in)
            && prdata_out[pasc_pkg::EX_LP_AN] == $past(lp_an_able_in))
        else $error("partner ability bits read wrong");
    rsvd18_zero_a: assert property (
        setup && idx == pasc_pkg::RSVD18_IDX |=> prdata_out == 32'h0000_0000)
        else $error("reserved word not zero");
    rpd_write_a: assert property (
        done && pwrite_in && hit_status
        |=> rpd_disable_out == $past(pwdata_in[pasc_pkg::ST_RPD_DIS]))
        else $error("power-down disable write lost");
    power_read_a: assert property (
        setup && !pwrite_in && hit_status && !$past(rst_in)
        |=> prdata_out[pasc_pkg::ST_PD100 -: 2] == $past({pd100_in, pd10_in}, 2))
        else $error("power bits read wrong");
    polarity_read_a: assert property (
        setup && !pwrite_in && hit_status
        |=> prdata_out[pasc_pkg::ST_POLARITY] == $past(polarity_rev_in))
        else $error("polarity bit read wrong");
    addr_hold_a: assert property (
        st_q.strap_cnt == 2'h3 |=> $stable(st_q.mgmt_addr))
        else $error("sampled address changed");
    special_hold_a: assert property (
        !(done && pwrite_in && hit_special) |=> $stable(st_q.special))
        else $error("special control changed without write");
    pattern_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {force_h_pattern_out, force_34_pattern_out} == $past(pwdata_in[13:12]))
        else $error("pattern control write lost");
    link_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {force_link_100_out, symbol_err_en_out} == $past(pwdata_in[11:10]))
        else $error("link control write lost");
    carrier_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {carrier_sense_dis_out, dyn_pd_dis_out} == $past(pwdata_in[9:8]))
        else $error("carrier control write lost");
    loopback_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {an_loopback_out, tx_tristate_out} == $past(pwdata_in[7:6]))
        else $error("loopback control write lost");
    polarity_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {force_pol_rev_out, auto_pol_dis_out} == $past(pwdata_in[5:4]))
        else $error("polarity control write lost");
    squelch_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {squelch_test_dis_out, ext_squelch_en_out} == $past(pwdata_in[3:2]))
        else $error("squelch control write lost");
    jabber_write_a: assert property (
        done && pwrite_in && hit_special
        |=> {link_check_dis_out, jabber_dis_out} == $past(pwdata_in[1:0]))
        else $error("link check control write lost");
    unmapped_err_a: assert property (
        setup && !mapped |=> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped access not refused");

endmodule : pasc_regs

`default_nettype wire

// [bench/pasc_partner.sv]
// Model of the remote link partner as seen through the negotiation logic.
// Assumes the bench calls its tasks at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module pasc_partner (
    // Clock
    input  wire logic       sys_clk_in,
    // Partner page, abilities and events
    output logic            np_out,
    output logic            ack_out,
    output logic            rf_out,
    output logic      [7:0] tech_out,
    output logic      [4:0] sel_out,
    output logic            np_able_out,
    output logic            an_able_out,
    output logic            pd_evt_out,
    output logic            pr_evt_out
);
    integer seed = 32'h7354;
    initial begin
        {np_out, ack_out, rf_out, tech_out, sel_out, np_able_out, an_able_out} = 18'h0;
        pd_evt_out = 1'b0;
        pr_evt_out = 1'b0;
    end
    // =====================================================================
    // New advertisement from the far end
    task automatic advertise;
        {np_out, ack_out, rf_out, tech_out, sel_out, np_able_out, an_able_out} <=
            18'($random(seed));
    endtask : advertise
    // One-cycle negotiation events
    task automatic pulse(input logic pd, input logic pr);
        pd_evt_out <= pd;
        pr_evt_out <= pr;
        @(posedge sys_clk_in);
        pd_evt_out <= 1'b0;
        pr_evt_out <= 1'b0;
    endtask : pulse
endmodule : pasc_partner
`default_nettype wire

// [bench/pasc_regs_bench.sv]
// Self-checking bench of the register bank over APB.
// Assumes zero-wait-state answers are not relied upon; all waits bounded.
`timescale 1ns/1ps
`default_nettype none
module pasc_regs_bench;
    logic        sys_clk_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rpd_dis;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        np, ack, rf, np_able, an_able, pd_evt, pr_evt;
    logic [7:0]  tech;
    logic [4:0]  sel, strap;
    logic [5:0]  sts;
    wire  [15:0] ctl;
    logic [15:0] v, sv;
    logic [29:0] bad = {6'h3f, 6'h13, 6'h07, 6'h04, 6'h00};
    logic [3:0]  rw16 = 4'h2;
    logic [33:0] notes[$];
    int          error_cnt = 0, check_count = 0;
    integer      seed = 32'h7354;
    always #5 sys_clk_in = ~sys_clk_in;

    pasc_partner pasc_partner_i (.sys_clk_in(sys_clk_in), .np_out(np), .ack_out(ack),
        .rf_out(rf), .tech_out(tech), .sel_out(sel), .np_able_out(np_able),
        .an_able_out(an_able), .pd_evt_out(pd_evt), .pr_evt_out(pr_evt));
    pasc_regs pasc_regs_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .lp_next_page_in(np), .lp_ack_in(ack), .lp_remote_fault_in(rf), .lp_tech_in(tech),
        .lp_selector_in(sel), .lp_np_able_in(np_able), .lp_an_able_in(an_able),
        .pd_fault_evt_in(pd_evt), .page_rx_evt_in(pr_evt), .rx_in_sync_in(sts[5]),
        .pd100_in(sts[4]), .pd10_in(sts[3]), .polarity_rev_in(sts[2]),
        .speed_100_in(sts[1]), .full_duplex_in(sts[0]), .addr_strap_in(strap),
        .rpd_disable_out(rpd_dis), .scrambler_bypass_out(ctl[15]),
        .coder_bypass_out(ctl[14]), .force_h_pattern_out(ctl[13]),
        .force_34_pattern_out(ctl[12]), .force_link_100_out(ctl[11]),
        .symbol_err_en_out(ctl[10]), .carrier_sense_dis_out(ctl[9]),
        .dyn_pd_dis_out(ctl[8]), .an_loopback_out(ctl[7]), .tx_tristate_out(ctl[6]),
        .force_pol_rev_out(ctl[5]), .auto_pol_dis_out(ctl[4]),
        .squelch_test_dis_out(ctl[3]), .ext_squelch_en_out(ctl[2]),
        .link_check_dis_out(ctl[1]), .jabber_dis_out(ctl[0]));

    // =====================================================================
    // Checking and closing
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // Note: {compare data, error flag, data}
    always @(posedge sys_clk_in) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                check({pslverr, prdata}, 33'h1ffffffff);
            end else begin
                logic [33:0] n;
                n = notes.pop_front();
                check({pslverr, n[33] ? prdata : 32'h0}, n[32:0]);
            end
        end
    end

    // =====================================================================
    // APB master, requests issued back to back
    task automatic apb(input logic [5:0] idx, input logic wr, input logic [33:0] note);
        int n;
        notes.push_back(note);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= wr ? {16'($random(seed)), v} : 32'($random(seed));
        @(posedge sys_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            final_report();
        end
    endtask : apb
    task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
        apb(idx, 1'b0, {2'h2, 16'h0, exp});
    endtask : rd
    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge sys_clk_in);
    endtask : idle

    // =====================================================================
    // Main sequence
    initial begin
        sts   = 6'($random(seed));
        strap = 5'($random(seed));
        v     = 16'h0;
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        check({16'h0, rpd_dis, ctl}, 33'h10000);
        rd(pasc_pkg::SPECIAL_IDX, 16'h0000);
        rd(pasc_pkg::EXPANSION_IDX, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 16'hffff : 16'($random(seed));
            sv = v;
            apb(pasc_pkg::SPECIAL_IDX, 1'b1, 34'h0);
            rd(pasc_pkg::SPECIAL_IDX, v);
            check({17'h0, ctl}, {17'h0, v});
            check({17'h0, ctl}, {17'h0, v});
            check({17'h0, ctl}, {17'h0, v});
            check({17'h0, ctl}, {17'h0, v});
            check({17'h0, ctl}, {17'h0, v});
            check({17'h0, ctl}, {17'h0, v});
            v = 16'($random(seed));
            rw16 = v[15:12];
            apb(pasc_pkg::STATUS_IDX, 1'b1, 34'h0);
            sts <= 6'($random(seed));
            idle(3);
            rd(pasc_pkg::STATUS_IDX, {rw16, sts[5:2], 1'b0, strap, sts[1:0]});
            check({32'h0, rpd_dis}, {32'h0, rw16[1]});
            pasc_partner_i.advertise();
            idle(2);
            rd(pasc_pkg::PARTNER_IDX, {np, ack, rf, tech, sel});
        end
        idle(1);
        pasc_partner_i.pulse(1'b1, 1'b1);
        rd(pasc_pkg::EXPANSION_IDX, {11'h0, 1'b1, np_able, 1'b0, 1'b1, an_able});
        rd(pasc_pkg::EXPANSION_IDX, {11'h0, 1'b0, np_able, 1'b0, 1'b0, an_able});
        fork
            rd(pasc_pkg::EXPANSION_IDX, {12'h0, np_able, 2'h0, an_able});
            begin
                @(posedge sys_clk_in);
                pasc_partner_i.pulse(1'b0, 1'b1);
            end
        join
        rd(pasc_pkg::EXPANSION_IDX, {12'h0, np_able, 2'h1, an_able});
        for (int i = 8; i <= 18; i++) begin
            if (i != 16 && i != 17) begin
                apb(6'(i), 1'b1, 34'h0);
                rd(6'(i), 16'h0000);
            end
        end
        for (int j = 0; j < 5; j++) begin
            apb(bad[j * 6 +: 6], 1'b1, {2'h3, 32'h0});
            apb(bad[j * 6 +: 6], 1'b0, {2'h3, 32'h0});
        end
        rd(pasc_pkg::SPECIAL_IDX, sv);
        idle(2);
        final_report();
    end
endmodule : pasc_regs_bench
`default_nettype wire
